// file: hw/tbc_top.sv
// Functional notes
// - source bit picks main or sub oscillator
// - display clock tap from source and select
// - duty bit gives 33/67 when next zero
// - low divider bits set carrier frequency
// - carrier series 1/4, 1/2, 1/12, 1/6 doubling
// - periodic flag set each interval expiry
// - time base divider untouched by reset
// - interrupt when flag and enable set
// - rate bits pick interval, reset to ones
// - rates divide by 128/4096/8192/16384
// - flag clear bit write-one, reads zero
// - watchdog enable writable once per reset
// - kick bit zeroes two-bit watchdog divider
// - divider overflow raises watchdog reset
// - carrier on routes carrier, else idle
// - carrier idle level from polarity bit
// - carrier pin enable claims shared pin
// - tone select picks buzzer divide ratio
// - tone on outputs buzzer, else idle
// - tone idle level while tone off
// - tone pin enable claims shared pin
// - unused bits ignore writes, read zero
module tbc_top
   import tbc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic main_osc_tick,
   input wire logic sub_osc_tick,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic periodic_interrupt,
   output logic watchdog_reset,
   output logic display_clk,
   output logic carrier_pin_out,
   output logic carrier_pin_sel,
   output logic tone_pin_out,
   output logic tone_pin_oe_n,
   output logic tone_pin_sel
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic tap(input logic [13:0] div, input logic [3:0] idx);
      tap = div[idx];
   endfunction : tap

   function automatic logic [3:0] pick(input logic s, input logic [3:0] lo,
                                       input logic [3:0] hi);
      pick = s ? hi : lo;
   endfunction : pick

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic divider_source_sel_reg;
   logic display_clock_sel_reg;
   logic carrier_duty_sel_reg;
   logic [3:0] carrier_divider_sel_reg;
   logic periodic_flag_reg;
   logic periodic_irq_enable_reg;
   logic [1:0] periodic_rate_sel_reg;
   logic watchdog_enable_reg;
   logic watchdog_written_reg;
   logic [1:0] watchdog_div_reg;
   logic carrier_on_reg;
   logic carrier_idle_level_reg;
   logic carrier_pin_enable_reg;
   logic tone_sel_reg;
   logic tone_on_reg;
   logic tone_idle_level_reg;
   logic tone_pin_enable_reg;
   logic [13:0] tb_div_reg = '0;
   logic [13:0] tb_div_prev_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic irq_reg;
   logic wd_fire_reg;
   logic disp_reg;
   logic car_out_reg;
   logic car_sel_reg;
   logic tone_out_reg;
   logic tone_oe_n_reg;
   logic tone_sel_pin_reg;

   logic sys_rst;
   logic tb_tick;
   logic rate_tap;
   logic periodic_event;
   logic [3:0] rate_idx;
   logic req;
   logic wr;
   logic [5:0] idx;
   logic wr_one;
   logic wr_two;
   logic wr_three;
   logic [7:0] wbyte;
   logic [7:0] rd_next;
   logic tone_clk;
   logic tone_level;

   tbc_car_if car_bus ();

   // internal resets include the watchdog timeout
   assign sys_rst = rst | wd_fire_reg;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign req = wb_cyc_i & wb_stb_i;
   assign idx = wb_adr_i[7:2];
   assign wr = req & wb_we_i & ack_reg & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];
   assign wr_one = wr & (idx == TBC_IDX_CFG_ONE);
   assign wr_two = wr & (idx == TBC_IDX_CFG_TWO);
   assign wr_three = wr & (idx == TBC_IDX_CFG_THREE);

   always_comb begin
      rd_next = '0;
      case (idx)
         TBC_IDX_CFG_ONE: begin
            rd_next[TBC_B1_SRC] = divider_source_sel_reg;
            rd_next[TBC_B1_DISP] = display_clock_sel_reg;
            rd_next[TBC_B1_DUTY] = carrier_duty_sel_reg;
            rd_next[TBC_B1_DIV_HI:TBC_B1_DIV_LO] = carrier_divider_sel_reg;
         end
         TBC_IDX_CFG_TWO: begin
            rd_next[TBC_B2_FLAG] = periodic_flag_reg;
            rd_next[TBC_B2_IE] = periodic_irq_enable_reg;
            rd_next[TBC_B2_RATE_HI:TBC_B2_RATE_LO] = periodic_rate_sel_reg;
            rd_next[TBC_B2_WDEN] = watchdog_enable_reg;
         end
         TBC_IDX_CFG_THREE: begin
            rd_next[TBC_B3_CON] = carrier_on_reg;
            rd_next[TBC_B3_CIDLE] = carrier_idle_level_reg;
            rd_next[TBC_B3_CPE] = carrier_pin_enable_reg;
            rd_next[TBC_B3_TSEL] = tone_sel_reg;
            rd_next[TBC_B3_TON] = tone_on_reg;
            rd_next[TBC_B3_TIDLE] = tone_idle_level_reg;
            rd_next[TBC_B3_TPE] = tone_pin_enable_reg;
         end
         default: rd_next = '0;
      endcase
   end

   // ------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= req & ~ack_reg;
         rdata_reg <= {24'h00_0000, rd_next};
      end
   end

   // ------------------------------------------------------------
   // first control register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         divider_source_sel_reg <= TBC_RST_CFG_ONE[TBC_B1_SRC];
         display_clock_sel_reg <= TBC_RST_CFG_ONE[TBC_B1_DISP];
         carrier_duty_sel_reg <= TBC_RST_CFG_ONE[TBC_B1_DUTY];
         carrier_divider_sel_reg <= TBC_RST_CFG_ONE[TBC_B1_DIV_HI:TBC_B1_DIV_LO];
      end else if (wr_one) begin
         divider_source_sel_reg <= wbyte[TBC_B1_SRC];
         display_clock_sel_reg <= wbyte[TBC_B1_DISP];
         carrier_duty_sel_reg <= wbyte[TBC_B1_DUTY];
         carrier_divider_sel_reg <= wbyte[TBC_B1_DIV_HI:TBC_B1_DIV_LO];
      end
   end

   // ------------------------------------------------------------
   // third control register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         carrier_on_reg <= TBC_RST_CFG_THREE[TBC_B3_CON];
         carrier_idle_level_reg <= TBC_RST_CFG_THREE[TBC_B3_CIDLE];
         carrier_pin_enable_reg <= TBC_RST_CFG_THREE[TBC_B3_CPE];
         tone_sel_reg <= TBC_RST_CFG_THREE[TBC_B3_TSEL];
         tone_on_reg <= TBC_RST_CFG_THREE[TBC_B3_TON];
         tone_idle_level_reg <= TBC_RST_CFG_THREE[TBC_B3_TIDLE];
         tone_pin_enable_reg <= TBC_RST_CFG_THREE[TBC_B3_TPE];
      end else if (wr_three) begin
         carrier_on_reg <= wbyte[TBC_B3_CON];
         carrier_idle_level_reg <= wbyte[TBC_B3_CIDLE];
         carrier_pin_enable_reg <= wbyte[TBC_B3_CPE];
         tone_sel_reg <= wbyte[TBC_B3_TSEL];
         tone_on_reg <= wbyte[TBC_B3_TON];
         tone_idle_level_reg <= wbyte[TBC_B3_TIDLE];
         tone_pin_enable_reg <= wbyte[TBC_B3_TPE];
      end
   end

   // ------------------------------------------------------------
   // second control register: enable and rate
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         periodic_irq_enable_reg <= TBC_RST_CFG_TWO[TBC_B2_IE];
         periodic_rate_sel_reg <= TBC_RST_CFG_TWO[TBC_B2_RATE_HI:TBC_B2_RATE_LO];
      end else if (wr_two) begin
         periodic_irq_enable_reg <= wbyte[TBC_B2_IE];
         periodic_rate_sel_reg <= wbyte[TBC_B2_RATE_HI:TBC_B2_RATE_LO];
      end
   end

   // ------------------------------------------------------------
   // time base divider, never reset
   // ------------------------------------------------------------
   assign tb_tick = divider_source_sel_reg ? main_osc_tick : sub_osc_tick;

   always_ff @(posedge core_clk) begin
      if (tb_tick) begin
         tb_div_reg <= tb_div_reg + 14'h0001;
      end
   end

   // ------------------------------------------------------------
   // periodic flag
   // ------------------------------------------------------------
   always_comb begin
      case (periodic_rate_sel_reg)
         2'b00: rate_idx = TBC_TAP_RATE_0;
         2'b01: rate_idx = TBC_TAP_RATE_1;
         2'b10: rate_idx = TBC_TAP_RATE_2;
         default: rate_idx = TBC_TAP_RATE_3;
      endcase
   end

   assign rate_tap = tap(tb_div_reg, rate_idx);
   assign periodic_event = tap(tb_div_prev_reg, rate_idx) & ~rate_tap;

   always_ff @(posedge core_clk) begin
      tb_div_prev_reg <= tb_div_reg;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         periodic_flag_reg <= TBC_RST_CFG_TWO[TBC_B2_FLAG];
      end else if (periodic_event) begin
         periodic_flag_reg <= 1'b1;
      end else if (wr_two && wbyte[TBC_B2_FCLR]) begin
         periodic_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= periodic_flag_reg & periodic_irq_enable_reg;
      end
   end

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         watchdog_enable_reg <= TBC_RST_CFG_TWO[TBC_B2_WDEN];
         watchdog_written_reg <= 1'b0;
      end else if (wr_two && !watchdog_written_reg) begin
         watchdog_enable_reg <= wbyte[TBC_B2_WDEN];
         watchdog_written_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         watchdog_div_reg <= '0;
      end else if (wr_two && wbyte[TBC_B2_KICK]) begin
         watchdog_div_reg <= '0;
      end else if (periodic_event) begin
         watchdog_div_reg <= watchdog_div_reg + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wd_fire_reg <= 1'b0;
      end else begin
         wd_fire_reg <= periodic_event & watchdog_enable_reg
                        & (watchdog_div_reg == TBC_WD_LAST)
                        & ~(wr_two & wbyte[TBC_B2_KICK]);
      end
   end

   // ------------------------------------------------------------
   // display clock
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (divider_source_sel_reg) begin
         disp_reg <= tap(tb_div_reg, pick(display_clock_sel_reg,
            TBC_TAP_DISP_MAIN_LO, TBC_TAP_DISP_MAIN_HI));
      end else begin
         disp_reg <= tap(tb_div_reg, pick(display_clock_sel_reg,
            TBC_TAP_DISP_SUB_LO, TBC_TAP_DISP_SUB_HI));
      end
   end

   // ------------------------------------------------------------
   // carrier generator
   // ------------------------------------------------------------
   assign car_bus.duty_sel = carrier_duty_sel_reg;
   assign car_bus.next_sel = carrier_divider_sel_reg[3];
   assign car_bus.step_sel = carrier_divider_sel_reg[2:0];
   assign car_bus.main_tick = main_osc_tick;

   tbc_carrier u_carrier (
      .core_clk(core_clk),
      .rst(sys_rst),
      .car(car_bus.gen)
   );

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         car_out_reg <= 1'b0;
         car_sel_reg <= 1'b0;
      end else begin
         car_sel_reg <= carrier_pin_enable_reg;
         if (carrier_on_reg) begin
            car_out_reg <= car_bus.carrier;
         end else begin
            car_out_reg <= carrier_idle_level_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // buzzer tone, open drain
   // ------------------------------------------------------------
   assign tone_clk = divider_source_sel_reg
      ? tap(tb_div_reg, pick(tone_sel_reg, TBC_TAP_TONE_MAIN_LO, TBC_TAP_TONE_MAIN_HI))
      : tap(tb_div_reg, pick(tone_sel_reg, TBC_TAP_TONE_SUB_LO, TBC_TAP_TONE_SUB_HI));
   assign tone_level = tone_on_reg ? tone_clk : tone_idle_level_reg;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tone_oe_n_reg <= 1'b1;
         tone_sel_pin_reg <= 1'b0;
         tone_out_reg <= 1'b0;
      end else begin
         tone_sel_pin_reg <= tone_pin_enable_reg;
         tone_out_reg <= 1'b0;
         tone_oe_n_reg <= ~(tone_pin_enable_reg & ~tone_level);
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wb_dat_o = rdata_reg;
   assign wb_ack_o = ack_reg;
   assign periodic_interrupt = irq_reg;
   assign watchdog_reset = wd_fire_reg;
   assign display_clk = disp_reg;
   assign carrier_pin_out = car_out_reg;
   assign carrier_pin_sel = car_sel_reg;
   assign tone_pin_out = tone_out_reg;
   assign tone_pin_oe_n = tone_oe_n_reg;
   assign tone_pin_sel = tone_sel_pin_reg;

endmodule : tbc_top

// file: hw/tbc_pkg.sv
package tbc_pkg;

   // ------------------------------------------------------------
   // register map (index; byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] TBC_IDX_CFG_ONE = 6'h10;
   localparam logic [5:0] TBC_IDX_CFG_TWO = 6'h11;
   localparam logic [5:0] TBC_IDX_CFG_THREE = 6'h1f;

   localparam logic [7:0] TBC_RST_CFG_ONE = 8'h00;
   localparam logic [7:0] TBC_RST_CFG_TWO = 8'h30;
   localparam logic [7:0] TBC_RST_CFG_THREE = 8'h00;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TBC_B1_SRC = 7;
   localparam int TBC_B1_DISP = 5;
   localparam int TBC_B1_DUTY = 4;
   localparam int TBC_B1_DIV_HI = 3;
   localparam int TBC_B1_DIV_LO = 0;
   localparam int TBC_B2_FLAG = 7;
   localparam int TBC_B2_IE = 6;
   localparam int TBC_B2_RATE_HI = 5;
   localparam int TBC_B2_RATE_LO = 4;
   localparam int TBC_B2_FCLR = 3;
   localparam int TBC_B2_WDEN = 1;
   localparam int TBC_B2_KICK = 0;
   localparam int TBC_B3_CON = 6;
   localparam int TBC_B3_CIDLE = 5;
   localparam int TBC_B3_CPE = 4;
   localparam int TBC_B3_TSEL = 3;
   localparam int TBC_B3_TON = 2;
   localparam int TBC_B3_TIDLE = 1;
   localparam int TBC_B3_TPE = 0;

   // ------------------------------------------------------------
   // time base divider taps (bit n toggles at source / 2^(n+1))
   // ------------------------------------------------------------
   localparam int TBC_TB_WIDTH = 14;
   localparam logic [3:0] TBC_TAP_DISP_SUB_LO = 4'h5;
   localparam logic [3:0] TBC_TAP_DISP_SUB_HI = 4'h6;
   localparam logic [3:0] TBC_TAP_DISP_MAIN_LO = 4'hc;
   localparam logic [3:0] TBC_TAP_DISP_MAIN_HI = 4'hd;
   localparam logic [3:0] TBC_TAP_RATE_0 = 4'h6;
   localparam logic [3:0] TBC_TAP_RATE_1 = 4'hb;
   localparam logic [3:0] TBC_TAP_RATE_2 = 4'hc;
   localparam logic [3:0] TBC_TAP_RATE_3 = 4'hd;
   localparam logic [3:0] TBC_TAP_TONE_SUB_LO = 4'h2;
   localparam logic [3:0] TBC_TAP_TONE_SUB_HI = 4'h3;
   localparam logic [3:0] TBC_TAP_TONE_MAIN_LO = 4'h9;
   localparam logic [3:0] TBC_TAP_TONE_MAIN_HI = 4'ha;

   // ------------------------------------------------------------
   // carrier generator
   // ------------------------------------------------------------
   localparam int TBC_CAR_WIDTH = 11;
   localparam logic [10:0] TBC_CAR_BASE_2 = 11'h002;
   localparam logic [10:0] TBC_CAR_BASE_4 = 11'h004;
   localparam logic [10:0] TBC_CAR_BASE_6 = 11'h006;
   localparam logic [10:0] TBC_CAR_BASE_12 = 11'h00c;
   localparam logic [10:0] TBC_CAR_ONE = 11'h001;
   localparam logic [10:0] TBC_CAR_THIRD_OF_6 = 11'h002;

   // watchdog divider
   localparam logic [1:0] TBC_WD_LAST = 2'h3;

endpackage : tbc_pkg

// file: hw/tbc_car_if.sv
interface tbc_car_if;
   logic duty_sel;
   logic next_sel;
   logic [2:0] step_sel;
   logic main_tick;
   logic carrier;

   modport gen (
      input duty_sel,
      input next_sel,
      input step_sel,
      input main_tick,
      output carrier
   );

   modport ctl (
      output duty_sel,
      output next_sel,
      output step_sel,
      output main_tick,
      input carrier
   );
endinterface : tbc_car_if

// file: hw/tbc_carrier.sv
module tbc_carrier
   import tbc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   tbc_car_if.gen car
);

   logic [10:0] cnt_reg;
   logic [10:0] base;
   logic [10:0] period;
   logic [10:0] high_len;

   // ------------------------------------------------------------
   // period and high time
   // ------------------------------------------------------------
   always_comb begin
      case ({car.duty_sel, car.next_sel})
         2'b01: base = TBC_CAR_BASE_4;
         2'b11: base = TBC_CAR_BASE_2;
         2'b00: base = TBC_CAR_BASE_12;
         default: base = TBC_CAR_BASE_6;
      endcase
      period = base << car.step_sel;
      if (car.duty_sel && !car.next_sel) begin
         high_len = TBC_CAR_THIRD_OF_6 << car.step_sel;
      end else begin
         high_len = period >> 1;
      end
   end

   // ------------------------------------------------------------
   // counter and output
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (car.main_tick) begin
         if (cnt_reg >= period - TBC_CAR_ONE) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + TBC_CAR_ONE;
         end
      end
   end

   assign car.carrier = (cnt_reg < high_len);

endmodule : tbc_carrier

// file: verification/tbc_top_asserts.sv
module tbc_top_asserts
   import tbc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic main_osc_tick,
   input wire logic sub_osc_tick,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic periodic_interrupt,
   input wire logic watchdog_reset,
   input wire logic display_clk,
   input wire logic carrier_pin_out,
   input wire logic carrier_pin_sel,
   input wire logic tone_pin_out,
   input wire logic tone_pin_oe_n,
   input wire logic tone_pin_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // bus access sequences
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst || watchdog_reset);

   sequence s_wr(logic [5:0] idx);
      wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == idx;
   endsequence

   sequence s_rd(logic [5:0] idx);
      wb_ack_o && wb_stb_i && !wb_we_i && wb_adr_i[7:2] == idx;
   endsequence

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_bit6_zero: assert property (s_rd(TBC_IDX_CFG_ONE) |-> !wb_dat_o[6])
      else $error("unused bit of first register reads one");
   a_bit7_zero: assert property (s_rd(TBC_IDX_CFG_THREE) |-> !wb_dat_o[7])
      else $error("unused bit of third register reads one");
   a_wo_zero: assert property (s_rd(TBC_IDX_CFG_TWO) |-> !wb_dat_o[3] && !wb_dat_o[0])
      else $error("write-only bit reads one");
   a_car_sel: assert property (s_wr(TBC_IDX_CFG_THREE)
      |-> ##2 carrier_pin_sel == $past(wb_dat_i[TBC_B3_CPE], 2))
      else $error("carrier pin select not following write");
   a_car_idle: assert property (s_wr(TBC_IDX_CFG_THREE) ##0 !wb_dat_i[TBC_B3_CON]
      |-> ##2 carrier_pin_out == $past(wb_dat_i[TBC_B3_CIDLE], 2))
      else $error("carrier idle level wrong");
   a_tone_sel: assert property (s_wr(TBC_IDX_CFG_THREE)
      |-> ##2 tone_pin_sel == $past(wb_dat_i[TBC_B3_TPE], 2))
      else $error("tone pin select not following write");
   a_tone_idle: assert property (s_wr(TBC_IDX_CFG_THREE) ##0 !wb_dat_i[TBC_B3_TON]
      ##0 wb_dat_i[TBC_B3_TPE] |-> ##2 tone_pin_oe_n == $past(wb_dat_i[TBC_B3_TIDLE], 2))
      else $error("tone idle level wrong");
   a_tone_data: assert property (!tone_pin_out)
      else $error("tone data not low");
   a_irq_mask: assert property (s_wr(TBC_IDX_CFG_TWO) ##0 !wb_dat_i[TBC_B2_IE]
      |-> ##2 !periodic_interrupt)
      else $error("interrupt while disabled");
   a_wd_pulse: assert property (disable iff (rst) watchdog_reset |=> !watchdog_reset)
      else $error("watchdog reset longer than one cycle");
endmodule : tbc_top_asserts

bind tbc_top tbc_top_asserts u_chk (.core_clk(core_clk), .rst(rst),
   .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .periodic_interrupt(periodic_interrupt), .watchdog_reset(watchdog_reset),
   .display_clk(display_clk), .carrier_pin_out(carrier_pin_out),
   .carrier_pin_sel(carrier_pin_sel), .tone_pin_out(tone_pin_out),
   .tone_pin_oe_n(tone_pin_oe_n), .tone_pin_sel(tone_pin_sel));

// file: verification/tb_top.sv
module tb_top
   import tbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic [5:0] idx; logic [7:0] wd; logic [7:0] exp;} tbc_row_t;

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic tick_on = 1'b0;
   logic main_osc_tick = 1'b0;
   logic sub_osc_tick = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, periodic_interrupt, watchdog_reset, display_clk, carrier_pin_out;
   logic carrier_pin_sel, tone_pin_out, tone_pin_oe_n, tone_pin_sel;
   logic car_q = 1'b0, tone_q = 1'b0, disp_q = 1'b0;
   int fail_count = 0, check_count = 0, wd_cnt = 0, car_rise = 0, tone_rise = 0, disp_rise = 0;
   tbc_row_t rows [7] = '{'{6'h10, 8'hff, 8'hbf}, '{6'h10, 8'h00, 8'h00},
      '{6'h1f, 8'hff, 8'h7f}, '{6'h1f, 8'h01, 8'h01}, '{6'h11, 8'h48, 8'h40},
      '{6'h11, 8'h31, 8'h30}, '{6'h12, 8'hff, 8'h00}};
   logic [7:0] car_cfg [5] = '{8'h88, 8'h89, 8'h98, 8'h80, 8'h90};
   int car_exp [5] = '{32, 16, 64, 11, 21};

   tbc_top dut (.core_clk(core_clk), .rst(rst), .main_osc_tick(main_osc_tick),
      .sub_osc_tick(sub_osc_tick), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periodic_interrupt(periodic_interrupt),
      .watchdog_reset(watchdog_reset), .display_clk(display_clk),
      .carrier_pin_out(carrier_pin_out), .carrier_pin_sel(carrier_pin_sel),
      .tone_pin_out(tone_pin_out), .tone_pin_oe_n(tone_pin_oe_n), .tone_pin_sel(tone_pin_sel));

   // ------------------------------------------------------------
   // clock, oscillator ticks, edge counters
   // ------------------------------------------------------------
   initial begin
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      main_osc_tick <= tick_on & ~main_osc_tick;
      sub_osc_tick <= tick_on & ~sub_osc_tick;
      car_q <= carrier_pin_out;
      tone_q <= tone_pin_oe_n;
      disp_q <= display_clk;
      if (carrier_pin_out === 1'b1 && car_q === 1'b0) car_rise++;
      if (tone_pin_oe_n === 1'b1 && tone_q === 1'b0) tone_rise++;
      if (display_clk === 1'b1 && disp_q === 1'b0) disp_rise++;
      if (watchdog_reset === 1'b1) wd_cnt++;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hf;
      wb_dat_i <= {24'h00_0000, wd};
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 64);
      rd = wb_dat_o;
      if (n >= 64) begin
         check("bus ack", 32'h0, 32'h1);
         conclude();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
   endtask : bus

   task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
      logic [31:0] d;
      bus(1'b1, idx, wd, d);
   endtask : wr

   task automatic rdc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      bus(1'b0, idx, 8'h00, d);
      check(nm, d, {24'h00_0000, exp});
   endtask : rdc

   task automatic wait_hi(input string nm, ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      check(nm, 32'(n < lim), 32'h1);
      if (n >= lim) conclude();
   endtask : wait_hi

   task automatic rng(input string nm, input int n, input int e);
      check(nm, 32'(n >= e - 1 && n <= e + 1), 32'h1);
   endtask : rng

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int n0, d0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdc("cfg1 reset", 6'h10, 8'h00);
      rdc("cfg2 reset", 6'h11, 8'h30);
      rdc("cfg3 reset", 6'h1f, 8'h00);
      check("tone release", tone_pin_oe_n, 32'h1);
      check("irq reset", periodic_interrupt, 32'h0);
      wr(6'h10, 8'h80);
      wr(6'h11, 8'h42);
      tick_on <= 1'b1;
      wait_hi("irq raised", periodic_interrupt, 600);
      rdc("flag set", 6'h11, 8'hc2);
      wr(6'h11, 8'h48);
      rdc("flag cleared", 6'h11, 8'h42);
      check("irq cleared", periodic_interrupt, 32'h0);
      repeat (5) begin
         repeat (200) @(posedge core_clk);
         wr(6'h11, 8'h41);
      end
      check("kicked no reset", wd_cnt, 32'h0);
      wait_hi("watchdog fire", watchdog_reset, 1400);
      repeat (2) @(posedge core_clk);
      rdc("wd clears cfg2", 6'h11, 8'h30);
      rdc("wd clears cfg1", 6'h10, 8'h00);
      tick_on <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         rdc("table readback", rows[i].idx, rows[i].exp);
      end
      tick_on <= 1'b1;
      wr(6'h1f, 8'h30);
      repeat (2) @(posedge core_clk);
      check("carrier idle", carrier_pin_out, 32'h1);
      wr(6'h1f, 8'h50);
      foreach (car_cfg[i]) begin
         wr(6'h10, car_cfg[i]);
         n0 = car_rise;
         repeat (256) @(posedge core_clk);
         rng("carrier rate", car_rise - n0, car_exp[i]);
      end
      wr(6'h10, 8'h00);
      wr(6'h1f, 8'h05);
      n0 = tone_rise;
      repeat (512) @(posedge core_clk);
      rng("tone low", tone_rise - n0, 32);
      wr(6'h1f, 8'h0d);
      wr(6'h10, 8'h20);
      d0 = disp_rise;
      n0 = tone_rise;
      repeat (512) @(posedge core_clk);
      rng("tone high", tone_rise - n0, 16);
      rng("display clock", disp_rise - d0, 2);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdc("rerun reset", 6'h1f, 8'h00);
      check("tone sel reset", tone_pin_sel, 32'h0);
      conclude();
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      check("run time", 32'h0, 32'h1);
      conclude();
   end
endmodule : tb_top
